// ---- hdl/twnv_pkg.sv ----
// package: constants and types for the two-wire memory slave
package twnv_pkg;
	localparam int TWNV_DEPTH = 8192;
	localparam int TWNV_AW = 13;
	localparam logic [3:0] TWNV_TYPE_CODE = 4'ha;
	localparam logic [12:0] TWNV_PROT_BASE = 13'h1800;
	localparam logic [12:0] TWNV_ADDR_LAST = 13'h1fff;
	localparam logic [12:0] TWNV_ADDR_ZERO = 13'h0000;
	localparam logic [2:0] TWNV_BIT_LAST = 3'h7;
	localparam logic [2:0] TWNV_BIT_FIRST = 3'h0;
	localparam logic [4:0] TWNV_ADDR_HI_BITS = 5'h1f;
	typedef enum logic [6:0] {
		TWNV_IDLE = 7'h01,
		TWNV_DEV = 7'h02,
		TWNV_AHI = 7'h04,
		TWNV_ALO = 7'h08,
		TWNV_WDAT = 7'h10,
		TWNV_RDAT = 7'h20,
		TWNV_MACK = 7'h40
	} twnv_state_t;
endpackage : twnv_pkg

// ---- hdl/twnv_mem_if.sv ----
// interface: array port between bus logic and storage
`timescale 1ns/1ps
`default_nettype none
interface twnv_mem_if;
	logic [12:0] addr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] rdata;
	modport ctl (output addr, output wdata, output we, input rdata);
	modport mem (input addr, input wdata, input we, output rdata);
endinterface : twnv_mem_if
`default_nettype wire

// ---- hdl/twnv_array.sv ----
// storage array of 8192 bytes in flip-flops
`timescale 1ns/1ps
`default_nettype none
module twnv_array import twnv_pkg::*; (
	input wire logic clk,
	twnv_mem_if.mem m
);
	logic [7:0] mem_r [TWNV_DEPTH];
	// write finishes in one system cycle, far inside one bus clock
	always_ff @(posedge clk) begin
		if (m.we) begin
			mem_r[m.addr] <= m.wdata;
		end
	end
	assign m.rdata = mem_r[m.addr];
endmodule : twnv_array
`default_nettype wire

// ---- hdl/twnv_slave.sv ----
// top: two-wire bus slave logic of the byte-wide nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE_01: 8192 byte locations, each reached serially bit by bit.
// RULE_02: take a 16-bit address; only the low 13 bits select.
// RULE_03: master should send zeros in the three unused address bits.
// RULE_04: answer only when select bits match the select pins.
// RULE_05: data line driven open-drain only: pull low or release.
// RULE_06: sample on clock rising edge, change output on falling edge.
// RULE_07: protect pin high blocks writes to the upper quarter.
// RULE_08: protect pin low allows writes everywhere.
// RULE_09: each write completes before the next transaction can start.
// RULE_10: always a slave; master alone makes the clock.
// RULE_11: decode start, stop, data bit and acknowledge.
// RULE_12: work at bus clocks up to 1 MHz, also 100 and 400 kHz.
// RULE_13: power-on reset brings interface to idle.
// RULE_14: first byte: type 1010, three select bits, direction bit.
// RULE_15: address advances after each byte and wraps 1fff to 0000.
// RULE_16: protected writes are not acknowledged and do not advance address.
// RULE_17: start or stop aborts any operation and readies the device.
// RULE_18: on address mismatch keep line released until next start.
module twnv_slave import twnv_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic [2:0] device_select_pins,
	input wire logic wp_i
);
	// ----------------------------------------------------------------
	// pin synchronisers and condition decode
	// ----------------------------------------------------------------
	// 100 MHz oversamples a 1 MHz bus clock fifty-fold per phase
	logic scl_s1_r, scl_s2_r, scl_d_r;
	logic sda_s1_r, sda_s2_r, sda_d_r;
	logic [2:0] sel_s1_r, sel_s2_r;
	logic wp_s1_r, wp_s2_r;
	// two cycles of pin latency are traded for metastability safety
	always_ff @(posedge clk or negedge rst_n) begin // RULE_12
		if (!rst_n) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s1_r <= scl_i;
			scl_s2_r <= scl_s1_r;
			scl_d_r <= scl_s2_r;
			sda_s1_r <= sda_i;
			sda_s2_r <= sda_s1_r;
			sda_d_r <= sda_s2_r;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_s1_r <= 3'h0;
			sel_s2_r <= 3'h0;
			wp_s1_r <= 1'b1;
			wp_s2_r <= 1'b1;
		end else begin
			sel_s1_r <= device_select_pins;
			sel_s2_r <= sel_s1_r;
			wp_s1_r <= wp_i;
			wp_s2_r <= wp_s1_r;
		end
	end
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_s2_r && !scl_d_r; // RULE_06 RULE_10
	assign scl_fall = !scl_s2_r && scl_d_r; // RULE_06
	assign start_c = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r; // RULE_11 RULE_17
	assign stop_c = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r; // RULE_11 RULE_17

	// ----------------------------------------------------------------
	// bit counter, shifter and phase
	// ----------------------------------------------------------------
	twnv_mem_if mif ();
	twnv_array u_array (
		.clk(clk),
		.m(mif)
	);
	twnv_state_t state_r;
	logic [2:0] bit_r;
	logic [7:0] shift_r;
	logic ack_phase_r;
	logic ack_drive_r;
	logic rd_r;
	logic [12:0] addr_r;
	logic [12:0] addr_nxt;
	logic [4:0] addr_hi_r;
	logic [7:0] out_r;
	logic byte_done, dev_match, prot_hit;
	logic [7:0] byte_in;
	assign byte_in = {shift_r[6:0], sda_s2_r};
	assign byte_done = scl_rise && !ack_phase_r && bit_r == TWNV_BIT_LAST; // RULE_01
	assign dev_match = byte_in[7:4] == TWNV_TYPE_CODE && byte_in[3:1] == sel_s2_r; // RULE_04 RULE_14
	assign prot_hit = wp_s2_r && addr_r >= TWNV_PROT_BASE; // RULE_07 RULE_08 RULE_16
	// wrap is an explicit compare against TWNV_ADDR_LAST
	assign addr_nxt = (addr_r == TWNV_ADDR_LAST) ? TWNV_ADDR_ZERO : addr_r + 13'h0001; // RULE_15

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_r <= TWNV_BIT_FIRST;
			shift_r <= 8'h00;
			ack_phase_r <= 1'b0;
		end else if (start_c || stop_c) begin
			bit_r <= TWNV_BIT_FIRST;
			ack_phase_r <= 1'b0;
		end else if (scl_rise) begin
			if (ack_phase_r) begin
				ack_phase_r <= 1'b0;
				bit_r <= TWNV_BIT_FIRST;
			end else begin
				shift_r <= byte_in; // RULE_06
				bit_r <= bit_r + 3'h1;
				ack_phase_r <= bit_r == TWNV_BIT_LAST;
			end
		end
	end

	// ----------------------------------------------------------------
	// transaction state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= TWNV_IDLE; // RULE_13
			rd_r <= 1'b0;
			ack_drive_r <= 1'b0;
		end else if (start_c) begin
			state_r <= TWNV_DEV; // RULE_17
			ack_drive_r <= 1'b0;
		end else if (stop_c) begin
			state_r <= TWNV_IDLE; // RULE_17
			ack_drive_r <= 1'b0;
		end else if (byte_done) begin
			case (state_r)
				TWNV_DEV: begin
					ack_drive_r <= dev_match;
					rd_r <= byte_in[0];
					state_r <= !dev_match ? TWNV_IDLE : // RULE_18
						(byte_in[0] ? TWNV_RDAT : TWNV_AHI);
				end
				TWNV_AHI: begin
					ack_drive_r <= 1'b1;
					state_r <= TWNV_ALO;
				end
				TWNV_ALO: begin
					ack_drive_r <= 1'b1;
					state_r <= TWNV_WDAT;
				end
				TWNV_WDAT: begin
					ack_drive_r <= !prot_hit; // RULE_16
					state_r <= prot_hit ? TWNV_IDLE : TWNV_WDAT;
				end
				TWNV_RDAT: begin
					ack_drive_r <= 1'b0;
					state_r <= TWNV_MACK;
				end
				default: begin
					ack_drive_r <= 1'b0;
					state_r <= TWNV_IDLE;
				end
			endcase
		end else if (scl_rise && ack_phase_r && state_r == TWNV_MACK) begin
			// master nack ends the read
			state_r <= sda_s2_r ? TWNV_IDLE : TWNV_RDAT;
		end else if (scl_fall && !ack_phase_r) begin
			ack_drive_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// address latch and array access
	// ----------------------------------------------------------------
	logic wr_fire;
	assign wr_fire = byte_done && state_r == TWNV_WDAT && !prot_hit; // RULE_07 RULE_08
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_r <= TWNV_ADDR_ZERO;
			addr_hi_r <= 5'h00;
		end else if (byte_done && state_r == TWNV_AHI) begin
			addr_hi_r <= byte_in[4:0] & TWNV_ADDR_HI_BITS; // RULE_02 RULE_03
		end else if (byte_done && state_r == TWNV_ALO) begin
			addr_r <= {addr_hi_r, byte_in}; // RULE_02
		end else if (wr_fire || (byte_done && state_r == TWNV_RDAT)) begin
			addr_r <= addr_nxt; // RULE_15 RULE_16
		end
	end
	assign mif.addr = addr_r;
	assign mif.wdata = byte_in;
	assign mif.we = wr_fire; // RULE_09

	// ----------------------------------------------------------------
	// open-drain output, changed on falling edges
	// ----------------------------------------------------------------
	logic drive_low_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_r <= 8'hff;
			drive_low_r <= 1'b0;
		end else if (start_c || stop_c) begin
			drive_low_r <= 1'b0;
		end else if (scl_fall) begin // RULE_06
			if (ack_phase_r) begin
				drive_low_r <= ack_drive_r && state_r != TWNV_MACK;
				if (state_r == TWNV_RDAT && ack_drive_r) begin
					out_r <= mif.rdata;
				end
			end else if (state_r == TWNV_RDAT) begin
				// first bit loads from array, later bits shift
				if (bit_r == TWNV_BIT_FIRST) begin
					drive_low_r <= !mif.rdata[7];
					out_r <= {mif.rdata[6:0], 1'b1};
				end else begin
					drive_low_r <= !out_r[7];
					out_r <= {out_r[6:0], 1'b1};
				end
			end else begin
				drive_low_r <= 1'b0;
			end
		end
	end
	assign sda_o = 1'b0; // RULE_05
	assign sda_oe_n = !drive_low_r; // RULE_05

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_mismatch_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
		state_r == TWNV_IDLE && !ack_phase_r |-> sda_oe_n)
		else $error("line driven while idle");
	a_stop_idle: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
		stop_c && !start_c |=> state_r == TWNV_IDLE)
		else $error("stop did not return to idle");
	a_start_dev: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
		start_c |=> state_r == TWNV_DEV && bit_r == TWNV_BIT_FIRST)
		else $error("start did not restart frame");
	a_prot_nowrite: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		mif.we |-> !(wp_s2_r && mif.addr >= TWNV_PROT_BASE))
		else $error("write into protected range");
	a_prot_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
		byte_done && state_r == TWNV_WDAT && prot_hit |=> $stable(addr_r) && !ack_drive_r)
		else $error("protected write advanced or acked");
	a_addr_wrap: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
		wr_fire && addr_r == TWNV_ADDR_LAST |=> addr_r == TWNV_ADDR_ZERO)
		else $error("address did not wrap");
	a_open_drain: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
		!sda_oe_n |-> !sda_o && state_r != TWNV_IDLE)
		else $error("line driven high or while idle");
	a_edge_change: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
		$changed(sda_oe_n) && !$past(start_c) && !$past(stop_c) |-> $past(scl_fall))
		else $error("output changed off falling edge");
	a_wp_low_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
		byte_done && state_r == TWNV_WDAT && !wp_s2_r |-> mif.we)
		else $error("unprotected write dropped");

	// ----------------------------------------------------------------
	// sequencing checks
	// ----------------------------------------------------------------
	a_read_dir: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
		state_r == TWNV_RDAT || state_r == TWNV_MACK |-> rd_r)
		else $error("read phase without read direction");
	a_ack_release: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
		scl_fall && !ack_phase_r && state_r != TWNV_RDAT |=> sda_oe_n)
		else $error("line held past the acknowledge slot");
	a_ack_drive: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
		scl_fall && ack_phase_r && ack_drive_r && state_r != TWNV_MACK |=> !sda_oe_n)
		else $error("acknowledge not driven");
	a_nack_end: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
		scl_rise && ack_phase_r && state_r == TWNV_MACK && sda_s2_r |=> state_r == TWNV_IDLE)
		else $error("read went on after master nack");
	a_addr_load: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
		byte_done && state_r == TWNV_ALO |=> addr_r == {addr_hi_r, $past(byte_in)})
		else $error("address latch load wrong");
	a_read_advance: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
		byte_done && state_r == TWNV_RDAT |=> addr_r == $past(addr_r) + 13'h0001)
		else $error("read did not advance address");
	a_mismatch_idle: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04 RULE_18
		byte_done && state_r == TWNV_DEV && !dev_match |=> state_r == TWNV_IDLE && !ack_drive_r)
		else $error("foreign address answered");
	a_byte_count: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
		byte_done |=> ack_phase_r && bit_r == TWNV_BIT_FIRST)
		else $error("byte length wrong");
	a_ack_slot: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
		scl_rise && ack_phase_r |=> !ack_phase_r && bit_r == TWNV_BIT_FIRST)
		else $error("acknowledge slot longer than one bit");
	a_low_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		byte_done && state_r == TWNV_WDAT && addr_r < TWNV_PROT_BASE |-> mif.we)
		else $error("open lower area write dropped");
	a_abort_release: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
		start_c || stop_c |=> sda_oe_n)
		else $error("line held after start or stop");
	a_sample_rise: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
		scl_rise && !ack_phase_r |=> shift_r[0] == $past(sda_s2_r))
		else $error("bit not taken on rising edge");
endmodule : twnv_slave
`default_nettype wire

// ---- verif/twnv_master.sv ----
// partner: two-wire bus master model that drives the clock and reports each nine-bit slot
`timescale 1ns/1ps
`default_nettype none
module twnv_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_m,
	output logic [8:0] res_d,
	output logic res_v
);
	// ----------------------------------------
	// idle bus: clock parked high, data released
	// ----------------------------------------
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		res_d = 9'h000;
		res_v = 1'b0;
	end
	// half of a 160 ns bus clock period
	task automatic half;
		repeat (8) @(posedge clk);
		#1;
	endtask : half
	// ----------------------------------------
	// framing: start and stop move data while the clock is high
	// ----------------------------------------
	task automatic start;
		sda_m = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_m = 1'b0;
		half();
		scl = 1'b0;
	endtask : start
	task automatic stop;
		sda_m = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_m = 1'b1;
		half();
	endtask : stop
	// eight bits then the acknowledge slot; a 1 releases the line
	task automatic xbyte(input logic [8:0] d);
		logic [8:0] r;
		r = 9'h000;
		for (int i = 8; i >= 0; i--) begin
			sda_m = d[i];
			half();
			scl = 1'b1;
			half();
			r[i] = sda;
			scl = 1'b0;
		end
		res_d = r;
		res_v = ~res_v;
	endtask : xbyte
endmodule : twnv_master
`default_nettype wire

// ---- verif/testbench.sv ----
// bench: two-wire memory slave against the bus master model
`timescale 1ns/1ps
`default_nettype none
module testbench import twnv_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp = 1'b0;
	logic [2:0] sel = 3'h5;
	logic [31:0] rng = 32'h48;
	logic [7:0] d [4];
	logic [8:0] exp_q [$];
	int fail_count = 0;
	int comparisons = 0;
	wire scl, sda_m, sda_o, sda_oe_n, res_v;
	wire [8:0] res_d;
	// pull-up: released by both parties reads high
	wire sda = sda_m & (sda_oe_n | sda_o);
	always #5 clk = ~clk;
	twnv_slave i_twnv_slave (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .device_select_pins(sel), .wp_i(wp));
	twnv_master i_twnv_master (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m),
		.res_d(res_d), .res_v(res_v));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction : rnd
	task automatic send(input logic [7:0] b, input logic ack);
		exp_q.push_back({b, ack});
		i_twnv_master.xbyte({b, 1'b1});
	endtask : send
	task automatic recv(input logic [7:0] b, input logic mack);
		exp_q.push_back({b, mack});
		i_twnv_master.xbyte({8'hff, mack});
	endtask : recv
	task automatic seta(input logic [15:0] a);
		i_twnv_master.start();
		send({TWNV_TYPE_CODE, sel, 1'b0}, 1'b0);
		send(a[15:8], 1'b0);
		send(a[7:0], 1'b0);
	endtask : seta
	task automatic rdst;
		i_twnv_master.start();
		send({TWNV_TYPE_CODE, sel, 1'b1}, 1'b0);
	endtask : rdst
	task automatic chk(input logic [8:0] got);
		logic [8:0] e;
		comparisons++;
		if (exp_q.size() == 0) begin
			fail_count++;
			$display("[FAIL] %0t slot %h arrived with no expectation", $time, got);
		end else begin
			e = exp_q.pop_front();
			if (got !== e) begin
				fail_count++;
				$display("[FAIL] %0t slot got %h expected %h", $time, got, e);
			end
		end
	endtask : chk
	task automatic summarize;
		if (exp_q.size() != 0) begin
			fail_count++;
			$display("[FAIL] %0t %0d slots never reported", $time, exp_q.size());
		end
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	// second process: each reported slot against the oldest note
	initial begin
		#1;
		forever begin
			@(res_v);
			// let the slot value settle through the port before taking it
			#1;
			chk(res_d);
		end
	end
	initial begin
		#300000;
		fail_count++;
		summarize();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 4; i++)
			d[i] = rnd();
		// foreign select, foreign type code, and silence afterwards
		i_twnv_master.start();
		send({TWNV_TYPE_CODE, sel ^ 3'h1, 1'b0}, 1'b1);
		send(8'h00, 1'b1);
		i_twnv_master.stop();
		i_twnv_master.start();
		send({4'hb, sel, 1'b0}, 1'b1);
		i_twnv_master.stop();
		$display("test select done");
		// burst write, then read back right away after a repeated start
		seta(16'h0123);
		for (int i = 0; i < 3; i++)
			send(d[i], 1'b0);
		i_twnv_master.stop();
		seta(16'h0123);
		rdst();
		for (int i = 0; i < 3; i++)
			recv(d[i], (i == 2));
		i_twnv_master.stop();
		$display("test burst done");
		// wrap at the top; high address bits set on purpose are ignored
		seta({3'h0, TWNV_ADDR_LAST});
		send(d[0], 1'b0);
		send(d[1], 1'b0);
		i_twnv_master.stop();
		seta({3'h7, TWNV_ADDR_LAST});
		rdst();
		recv(d[0], 1'b0);
		recv(d[1], 1'b1);
		i_twnv_master.stop();
		$display("test wrap done");
		// write protect: last open byte accepted, first guarded byte refused
		seta({3'h0, TWNV_PROT_BASE});
		send(d[2], 1'b0);
		i_twnv_master.stop();
		wp = 1'b1;
		seta({3'h0, TWNV_PROT_BASE - 13'h1});
		send(d[3], 1'b0);
		send(d[0], 1'b1);
		i_twnv_master.stop();
		seta({3'h0, TWNV_PROT_BASE - 13'h1});
		rdst();
		recv(d[3], 1'b0);
		recv(d[2], 1'b1);
		i_twnv_master.stop();
		$display("test protect done");
		summarize();
	end
endmodule : testbench
`default_nettype wire
